// ---- core/asgcp_map.svh ----
// Constants of the ASCII setpoint and gas command parser
`ifndef ASGCP_MAP_SVH
`define ASGCP_MAP_SVH
// Character codes, compared after case folding
`define ASGCP_CR      8'h0d
`define ASGCP_SP      8'h20
`define ASGCP_MINUS   8'h2d
`define ASGCP_DOT     8'h2e
`define ASGCP_EQ      8'h3d
`define ASGCP_QM      8'h3f
`define ASGCP_AT      8'h40
`define ASGCP_LA      8'h41
`define ASGCP_LZ      8'h5a
`define ASGCP_LC      8'h43
`define ASGCP_LD      8'h44
`define ASGCP_LE      8'h45
`define ASGCP_LG      8'h47
`define ASGCP_LH      8'h48
`define ASGCP_LL      8'h4c
`define ASGCP_LM      8'h4d
`define ASGCP_LP      8'h50
`define ASGCP_LS      8'h53
`define ASGCP_LU      8'h55
`define ASGCP_LV      8'h56
`define ASGCP_LW      8'h57
// Literal tails: "C", "91=", "=", "?M9"
`define ASGCP_EXP_C   24'h430000
`define ASGCP_EXP_W   24'h39313d
`define ASGCP_EXP_EQ  24'h3d0000
`define ASGCP_EXP_FW  24'h3f4d39
// User mix range and mix limits
`define ASGCP_MIX_LO  8'hec
`define ASGCP_MAX_GAS 8'hff
`define ASGCP_NAME_MAX 3'h6
`define ASGCP_MIN_PAIR 3'h2
`define ASGCP_MAX_PAIR 3'h5
`define ASGCP_PCT_FULL 17'h02710
// Reset values
`define ASGCP_RST_ID  8'h41
`define ASGCP_RST_IVL 16'h0032
// Timing
`define ASGCP_CLK_NS  10
`define ASGCP_MS_NS   1000000
`define ASGCP_MS_CYC  (`ASGCP_MS_NS / `ASGCP_CLK_NS)
`define ASGCP_AZ_MS   12'h7d0
`endif

// ---- core/asgcp_pkg.sv ----
// Types of the ASCII setpoint and gas command parser
package asgcp_pkg;
    typedef enum logic [1:0] {
        VALVE_RUN, VALVE_HOLD_POS, VALVE_HOLD_CLOSED
    } asgcp_valve_t;
    typedef enum logic [1:0] {
        REP_FRAME, REP_MIX, REP_FW, REP_ACK
    } asgcp_rep_kind_t;
    typedef struct packed {
        logic            valid;
        asgcp_rep_kind_t kind;
    } asgcp_reply_t;
    typedef struct packed {
        logic [7:0]        num;
        logic [2:0]        count;
        logic [4:0][13:0]  pct;
        logic [4:0][7:0]   gas;
    } asgcp_mix_t;
endpackage : asgcp_pkg

// ---- core/asgcp_parser.sv ----
// Line-oriented ASCII command interpreter of the flow controller
`include "asgcp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module asgcp_parser #(
    parameter int unsigned MS_CYCLES = `ASGCP_MS_CYC
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    // Received characters from the serial receiver
    input  wire logic [7:0]             rx_data_i,
    input  wire logic                   rx_valid_i,
    output logic                        rx_ready_o,
    // Configuration levels
    input  wire logic                   sp_source_serial_i,
    input  wire logic                   bidir_i,
    input  wire logic                   autozero_en_i,
    // Front panel
    input  wire logic [3:0]             panel_btn_i,
    output logic [3:0]                  panel_btn_o,
    output logic                        lockout_indicator_o,
    // Controller state
    output logic signed [24:0]          setpoint_o,
    output logic                        setpoint_raw_o,
    output logic [7:0]                  gas_o,
    output asgcp_pkg::asgcp_valve_t     valve_mode_o,
    output logic                        tare_flow_o,
    output logic                        tare_abs_pressure_cmd_o,
    output logic [7:0]                  unit_id_o,
    output logic                        streaming_o,
    output logic [15:0]                 stream_interval_o,
    output logic                        stream_tick_o,
    // Replies and mixes
    output asgcp_pkg::asgcp_reply_t     reply_o,
    output asgcp_pkg::asgcp_mix_t       mix_o,
    output logic [19:0]                 mix_used_o
);
    import asgcp_pkg::*;

    typedef enum {ST_ID, ST_CMD, ST_G, ST_H, ST_V, ST_NUM, ST_EXP,
        ST_NEWID, ST_FLD, ST_END, ST_SKIP, ST_DONE} asgcp_st_t;
    typedef enum {C_NONE, C_POLL, C_SP, C_SPINT, C_GAS, C_TARE, C_TAREP,
        C_HOLDP, C_HOLDC, C_CANCEL, C_LOCK, C_UNLOCK, C_W91, C_NEWID,
        C_FW, C_GM, C_GD} asgcp_cmd_t;

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [3:0] btn_s1;
    logic [3:0] btn_s2;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            btn_s1 <= 4'h0;
            btn_s2 <= 4'h0;
        end else begin
            btn_s1 <= panel_btn_i;
            btn_s2 <= btn_s1;
        end
    end

    // ************************************************************
    // Parser state
    // ************************************************************
    asgcp_st_t        state;
    asgcp_st_t        exp_next;
    asgcp_cmd_t       cmd;
    logic             id_ok, a_first, neg, dot, bad;
    logic [23:0]      acc;
    logic [1:0]       frac;
    logic [23:0]      exp_q;
    logic [1:0]       exp_n;
    logic [7:0]       new_id;
    logic [3:0]       fld;
    logic [2:0]       flen;
    logic [7:0]       mix_req;
    logic [2:0]       npair;
    logic [4:0][13:0] pct;
    logic [4:0][7:0]  gnum;
    logic             lock;

    // Case folding and character classes
    wire logic       lower = rx_data_i >= 8'h61 && rx_data_i <= 8'h7a;
    wire logic [7:0] ch = lower ? 8'(rx_data_i - 8'h20) : rx_data_i;
    wire logic       take = rx_valid_i && rx_ready_o;
    wire logic       is_cr = ch == `ASGCP_CR;
    wire logic       is_dig = ch >= 8'h30 && ch <= 8'h39;
    wire logic       is_let = ch >= `ASGCP_LA && ch <= `ASGCP_LZ;
    wire logic       name_ch = is_let || is_dig || ch == `ASGCP_DOT
                               || ch == `ASGCP_MINUS;
    wire logic [23:0] acc_dig = 24'(acc * 24'h00000a + {20'h0, ch[3:0]});
    // Value in hundredths; digits past the second decimal are dropped
    wire logic [23:0] hund = (dot && frac == 2'h2) ? acc
                             : (dot && frac == 2'h1) ? 24'(acc * 24'h00000a)
                             : 24'(acc * 24'h000064);
    // Mix field bookkeeping
    wire logic [3:0] fo = 4'(fld - 4'h2);
    wire logic [2:0] pidx = fo[3:1];
    wire logic       fcommit = take && state == ST_FLD && flen != 3'h0
                               && (ch == `ASGCP_SP || is_cr);

    // Handshake: one idle cycle while a finished line is executed
    assign rx_ready_o = state != ST_DONE;

    // Character walk; every line is acted on only at its terminator
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_ID; exp_next <= ST_END; cmd <= C_NONE;
            id_ok <= 1'b0; a_first <= 1'b0; neg <= 1'b0; dot <= 1'b0;
            bad <= 1'b0; acc <= 24'h0; frac <= 2'h0; exp_q <= 24'h0;
            exp_n <= 2'h0; new_id <= 8'h0; fld <= 4'h0; flen <= 3'h0;
            mix_req <= 8'h0; npair <= 3'h0; pct <= '0; gnum <= '0;
        end else if (state == ST_DONE) begin
            state <= ST_ID;
        end else if (take) begin
            if (fcommit) begin
                fld <= 4'(fld + 4'h1);
                flen <= 3'h0; acc <= 24'h0; dot <= 1'b0; frac <= 2'h0;
                if (fld == 4'h1) begin
                    mix_req <= acc[7:0];
                    if (acc > 24'h0000ff) bad <= 1'b1;
                end else if (fld >= 4'h2) begin
                    if (pidx >= 3'h5) bad <= 1'b1;
                    else if (!fo[0]) begin
                        pct[pidx] <= hund[13:0];
                        if (hund > 24'h002710) bad <= 1'b1;
                    end else begin
                        gnum[pidx] <= acc[7:0];
                        npair <= 3'(pidx + 3'h1);
                        if (acc > 24'h0000ff || dot) bad <= 1'b1;
                    end
                end
            end
            case (state)
                ST_ID: begin
                    // Fresh line: clear the working fields
                    cmd <= C_NONE; neg <= 1'b0; dot <= 1'b0; bad <= 1'b0;
                    acc <= 24'h0; frac <= 2'h0; fld <= 4'h0; flen <= 3'h0;
                    npair <= 3'h0; mix_req <= 8'h0;
                    id_ok <= ch == unit_id_o;
                    a_first <= ch == `ASGCP_LA;
                    if (is_cr) state <= ST_ID;
                    else if (ch == unit_id_o || ch == `ASGCP_LA)
                        state <= ST_CMD;
                    else state <= ST_SKIP;
                end
                ST_CMD: begin
                    if (!id_ok && !(a_first && ch == `ASGCP_LV))
                        state <= is_cr ? ST_ID : ST_SKIP;
                    else if (is_cr) begin
                        cmd <= C_POLL; state <= ST_DONE;
                    end else if (ch == `ASGCP_LS) begin
                        cmd <= C_SP; state <= ST_NUM;
                    end else if (is_dig) begin
                        cmd <= C_SPINT; acc <= {20'h0, ch[3:0]};
                        state <= ST_NUM;
                    end else if (ch == `ASGCP_LG) state <= ST_G;
                    else if (ch == `ASGCP_LH) state <= ST_H;
                    else if (ch == `ASGCP_LV) begin
                        cmd <= id_ok ? C_TARE : C_NONE; state <= ST_V;
                    end else if (ch == `ASGCP_LP) begin
                        cmd <= C_TAREP; exp_q <= `ASGCP_EXP_C;
                        exp_n <= 2'h1; exp_next <= ST_END; state <= ST_EXP;
                    end else if (ch == `ASGCP_LC) begin
                        cmd <= C_CANCEL; state <= ST_END;
                    end else if (ch == `ASGCP_LL) begin
                        cmd <= C_LOCK; state <= ST_END;
                    end else if (ch == `ASGCP_LU) begin
                        cmd <= C_UNLOCK; state <= ST_END;
                    end else if (ch == `ASGCP_LW) begin
                        cmd <= C_W91; exp_q <= `ASGCP_EXP_W;
                        exp_n <= 2'h3; exp_next <= ST_NUM; state <= ST_EXP;
                    end else if (ch == `ASGCP_AT) begin
                        cmd <= C_NEWID; exp_q <= `ASGCP_EXP_EQ;
                        exp_n <= 2'h1; exp_next <= ST_NEWID; state <= ST_EXP;
                    end else if (ch == `ASGCP_QM) begin
                        cmd <= C_FW; exp_q <= `ASGCP_EXP_FW;
                        exp_n <= 2'h3; exp_next <= ST_END; state <= ST_EXP;
                    end else state <= ST_SKIP;
                end
                ST_G: begin
                    if (is_dig) begin
                        cmd <= C_GAS; acc <= {20'h0, ch[3:0]};
                        state <= ST_NUM;
                    end else if (ch == `ASGCP_LM) begin
                        cmd <= C_GM; state <= ST_FLD;
                    end else if (ch == `ASGCP_LD) begin
                        cmd <= C_GD; state <= ST_NUM;
                    end else state <= is_cr ? ST_ID : ST_SKIP;
                end
                ST_H: begin
                    if (ch == `ASGCP_LP) cmd <= C_HOLDP;
                    else if (ch == `ASGCP_LC) cmd <= C_HOLDC;
                    state <= (ch == `ASGCP_LP || ch == `ASGCP_LC) ? ST_END
                             : is_cr ? ST_ID : ST_SKIP;
                end
                ST_V: begin
                    if (is_cr) state <= id_ok ? ST_DONE : ST_ID;
                    else if (ch == `ASGCP_LE && a_first) begin
                        cmd <= C_FW; state <= ST_END;
                    end else state <= ST_SKIP;
                end
                ST_NUM: begin
                    if (is_cr) state <= ST_DONE;
                    else if (is_dig && !(dot && frac == 2'h2)) begin
                        acc <= acc_dig;
                        if (dot) frac <= 2'(frac + 2'h1);
                    end else if (is_dig) state <= ST_NUM;
                    else if (ch == `ASGCP_DOT && cmd == C_SP && !dot)
                        dot <= 1'b1;
                    else if (ch == `ASGCP_MINUS && cmd == C_SP
                             && acc == 24'h0 && !neg)
                        neg <= 1'b1;
                    else if (!(ch == `ASGCP_SP && cmd == C_GD
                               && acc == 24'h0))
                        state <= ST_SKIP;
                end
                ST_EXP: begin
                    if (ch == exp_q[23:16]) begin
                        exp_q <= {exp_q[15:0], 8'h00};
                        exp_n <= 2'(exp_n - 2'h1);
                        if (exp_n == 2'h1) state <= exp_next;
                    end else state <= is_cr ? ST_ID : ST_SKIP;
                end
                ST_NEWID: begin
                    new_id <= ch;
                    state <= (is_let || ch == `ASGCP_AT) ? ST_END
                             : is_cr ? ST_ID : ST_SKIP;
                end
                ST_FLD: begin
                    if (is_cr) state <= ST_DONE;
                    else if (ch != `ASGCP_SP) begin
                        flen <= (flen == 3'h7) ? flen : 3'(flen + 3'h1);
                        if (fld == 4'h0) begin
                            if (!name_ch || flen >= `ASGCP_NAME_MAX)
                                bad <= 1'b1;
                        end else if (is_dig && !(dot && frac == 2'h2)) begin
                            acc <= acc_dig;
                            if (dot) frac <= 2'(frac + 2'h1);
                        end else if (ch == `ASGCP_DOT && !dot) dot <= 1'b1;
                        else if (!is_dig) bad <= 1'b1;
                    end
                end
                ST_END: state <= is_cr ? ST_DONE : ST_SKIP;
                ST_SKIP: if (is_cr) state <= ST_ID;
                default: state <= ST_ID;
            endcase
        end
    end

    // ************************************************************
    // Execution of a finished line
    // ************************************************************
    logic [16:0] pct_sum;
    logic        free_found;
    logic [4:0]  free_idx;
    // Highest free slot wins, so allocation runs down from 255
    always_comb begin
        pct_sum = 17'h0;
        free_found = 1'b0;
        free_idx = 5'h0;
        for (int i = 0; i < 5; i++) begin
            if (3'(i) < npair) pct_sum = 17'(pct_sum + {3'h0, pct[i]});
        end
        for (int i = 0; i < 20; i++) begin
            if (!mix_used_o[i]) begin
                free_found = 1'b1;
                free_idx = 5'(i);
            end
        end
    end
    wire logic [7:0] tgt = (mix_req == 8'h0)
                           ? 8'(`ASGCP_MIX_LO + {3'h0, free_idx}) : mix_req;
    wire logic [4:0] tidx = 5'(tgt - `ASGCP_MIX_LO);
    wire logic       mix_ok = !bad && npair >= `ASGCP_MIN_PAIR
        && npair <= `ASGCP_MAX_PAIR && fld == {npair, 1'b0} + 4'h2
        && pct_sum == `ASGCP_PCT_FULL
        && (mix_req == 8'h0 ? free_found : mix_req >= `ASGCP_MIX_LO);
    wire logic [4:0] aidx = 5'(acc[7:0] - `ASGCP_MIX_LO);
    wire logic in_mix = acc >= {16'h0, `ASGCP_MIX_LO}
                        && acc <= {16'h0, `ASGCP_MAX_GAS};
    wire logic gas_ok = acc <= {16'h0, `ASGCP_MAX_GAS}
                        && (!in_mix || mix_used_o[aidx]);
    wire logic sp_ok = sp_source_serial_i && (!neg || bidir_i);
    wire logic signed [24:0] sp_val = neg ? -$signed({1'b0, hund})
                                          : $signed({1'b0, hund});
    wire logic done = state == ST_DONE;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            setpoint_o <= 25'h0; setpoint_raw_o <= 1'b0; gas_o <= 8'h0;
            valve_mode_o <= VALVE_RUN; lock <= 1'b0;
            unit_id_o <= `ASGCP_RST_ID; stream_interval_o <= `ASGCP_RST_IVL;
            tare_abs_pressure_cmd_o <= 1'b0; reply_o <= '0;
            mix_o <= '0; mix_used_o <= 20'h0;
        end else begin
            tare_abs_pressure_cmd_o <= done && cmd == C_TAREP;
            reply_o <= '0;
            if (done) begin
                case (cmd)
                    C_POLL: reply_o <= '{1'b1, REP_FRAME};
                    C_SP: if (sp_ok) begin
                        setpoint_o <= sp_val; setpoint_raw_o <= 1'b0;
                        reply_o <= '{1'b1, REP_FRAME};
                    end
                    C_SPINT: if (sp_ok) begin
                        setpoint_o <= $signed({1'b0, acc});
                        setpoint_raw_o <= 1'b1;
                        reply_o <= '{1'b1, REP_FRAME};
                    end
                    C_GAS: if (gas_ok) begin
                        gas_o <= acc[7:0];
                        reply_o <= '{1'b1, REP_FRAME};
                    end
                    C_HOLDP: valve_mode_o <= VALVE_HOLD_POS;
                    C_HOLDC: valve_mode_o <= VALVE_HOLD_CLOSED;
                    C_CANCEL: valve_mode_o <= VALVE_RUN;
                    C_LOCK: lock <= 1'b1;
                    C_UNLOCK: lock <= 1'b0;
                    C_W91: if (acc != 24'h0 && acc <= 24'h00ffff) begin
                        stream_interval_o <= acc[15:0];
                        reply_o <= '{1'b1, REP_ACK};
                    end
                    C_NEWID: unit_id_o <= new_id;
                    C_FW: reply_o <= '{1'b1, REP_FW};
                    C_GM: if (mix_ok) begin
                        mix_used_o[tidx] <= 1'b1;
                        mix_o <= '{tgt, npair, pct, gnum};
                        reply_o <= '{1'b1, REP_MIX};
                    end
                    C_GD: if (in_mix && mix_used_o[aidx]) begin
                        mix_used_o[aidx] <= 1'b0;
                        reply_o <= '{1'b1, REP_ACK};
                    end
                    default: reply_o <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // Millisecond base, streaming and automatic re-zero
    // ************************************************************
    logic [16:0] ms_cnt;
    logic [15:0] st_cnt;
    logic [11:0] az_cnt;
    logic        az_q, tare_q;
    wire logic ms_tick = ms_cnt == 17'(MS_CYCLES - 1);
    // Zero setpoint held in normal control; holds freeze the loop
    wire logic az_arm = autozero_en_i && setpoint_o == 25'h0
                        && valve_mode_o == VALVE_RUN;
    assign streaming_o = unit_id_o == `ASGCP_AT;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt <= 17'h0; st_cnt <= 16'h0; stream_tick_o <= 1'b0;
            az_cnt <= 12'h0; az_q <= 1'b0; tare_q <= 1'b0;
        end else begin
            ms_cnt <= ms_tick ? 17'h0 : 17'(ms_cnt + 17'h1);
            stream_tick_o <= 1'b0;
            tare_q <= done && cmd == C_TARE;
            az_q <= 1'b0;
            if (!streaming_o) st_cnt <= 16'h0;
            else if (ms_tick) begin
                if (17'(st_cnt) + 17'h1 >= 17'(stream_interval_o)) begin
                    st_cnt <= 16'h0;
                    stream_tick_o <= 1'b1;
                end else st_cnt <= 16'(st_cnt + 16'h1);
            end
            if (!az_arm) az_cnt <= 12'h0;
            else if (ms_tick && az_cnt < `ASGCP_AZ_MS) begin
                az_cnt <= 12'(az_cnt + 12'h1);
                az_q <= az_cnt == 12'(`ASGCP_AZ_MS - 12'h1);
            end
        end
    end
    assign tare_flow_o = tare_q || az_q;

    // Panel buttons are swallowed while locked out
    assign lockout_indicator_o = lock;
    assign panel_btn_o = lock ? 4'h0 : btn_s2;
endmodule : asgcp_parser
`default_nettype wire

// ---- verification/asgcp_asserts.sv ----
// Checker of the command parser's port behaviour
`timescale 1ns/100ps
`default_nettype none
module asgcp_asserts (
    input wire logic clk_i, resetn_i, rx_valid_i, rx_ready_o, bidir_i,
    input wire logic [7:0] rx_data_i, unit_id_o, gas_o,
    input wire logic sp_source_serial_i, lockout_indicator_o, streaming_o,
    input wire logic stream_tick_o, tare_abs_pressure_cmd_o,
    input wire logic [3:0] panel_btn_o,
    input wire logic signed [24:0] setpoint_o,
    input wire logic [19:0] mix_used_o,
    input wire asgcp_pkg::asgcp_reply_t reply_o
);
    import asgcp_pkg::*;
    // A line terminator taken; replies, gas changes and pressure tares must trace back to one
    wire cr = rx_valid_i && rx_ready_o && rx_data_i == 8'h0d;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_stall; !rx_ready_o |-> $past(cr) ##1 rx_ready_o; endproperty
    a_stall: assert property (p_stall) else $error("bad stall");
    property p_late; reply_o.valid |-> $past(cr, 2); endproperty
    a_late: assert property (p_late) else $error("early reply");
    property p_gas; $changed(gas_o) |-> $past(cr, 2) &&
        (gas_o < 8'hec || mix_used_o[gas_o - 8'hec]); endproperty
    a_gas: assert property (p_gas) else $error("bad gas");
    property p_src; $changed(setpoint_o) |-> $past(sp_source_serial_i, 1)
        && (setpoint_o >= 0 || $past(bidir_i, 1)); endproperty
    a_src: assert property (p_src) else $error("bad setpoint");
    property p_echo; $changed(setpoint_o) |->
        reply_o.valid && reply_o.kind == REP_FRAME; endproperty
    a_echo: assert property (p_echo) else $error("no frame");
    property p_lock; lockout_indicator_o |-> panel_btn_o == 4'h0; endproperty
    a_lock: assert property (p_lock) else $error("buttons live");
    property p_id; streaming_o == (unit_id_o == 8'h40) && (streaming_o ||
        unit_id_o inside {[8'h41:8'h5a]}); endproperty
    a_id: assert property (p_id) else $error("bad unit id");
    property p_tick; stream_tick_o |=> !stream_tick_o [*8]; endproperty
    a_tick: assert property (p_tick) else $error("ticks close");
    property p_tare; tare_abs_pressure_cmd_o |->
        $past(cr, 2) ##1 !tare_abs_pressure_cmd_o; endproperty
    a_tare: assert property (p_tare) else $error("bad tare");
    c_fw: cover property (reply_o.valid && reply_o.kind == REP_FW);
    c_tick: cover property (stream_tick_o);
    c_lock: cover property ($rose(lockout_indicator_o));
endmodule : asgcp_asserts
bind asgcp_parser asgcp_asserts i_asgcp_asserts (.*);
`default_nettype wire

// ---- verification/asgcp_host.sv ----
// Host terminal model typing command lines into the parser
`timescale 1ns/100ps
`default_nettype none
module asgcp_host (
    // Clock and handshake
    input  wire logic      clk_i,
    input  wire logic      ready_i,
    // Character towards the parser
    output var logic [7:0] data_o,
    output var logic       valid_o
);
    int gap = 0; // Idle cycles between characters: a slow host
    initial {data_o, valid_o} = 9'h000;
    // Ready is combinational, so it is judged mid-cycle, not at the edge
    task automatic send(input string s);
        logic r;
        for (int k = 0; k < s.len(); k++) begin
            data_o = s[k];
            valid_o = 1'b1;
            do begin
                @(negedge clk_i) r = ready_i;
                @(posedge clk_i) #1;
            end while (!r);
            if (gap > 0) begin
                valid_o = 1'b0;
                repeat (gap) @(posedge clk_i);
                #1;
            end
        end
        valid_o = 1'b0;
        data_o = ~data_o; // Idle line never repeats the last character
    endtask : send
endmodule : asgcp_host
`default_nettype wire

// ---- verification/tb_ascii_setpoint_gas_cmd_parser.sv ----
// Self-checking bench of the command parser
`timescale 1ns/100ps
`default_nettype none
module tb_ascii_setpoint_gas_cmd_parser;
    import asgcp_pkg::*;
    logic clk_i = 0, resetn_i = 0, src = 1, bidir = 1, az = 0, valid;
    logic [3:0] btn = 4'hf, pbtn;
    logic [7:0] data, gas, uid;
    logic ready, raw, lock, tick, tare, pabs, strm;
    logic signed [24:0] sp;
    logic [15:0] ivl;
    logic [19:0] used;
    asgcp_valve_t vm;
    asgcp_reply_t rep;
    asgcp_mix_t mix;
    asgcp_rep_kind_t lastk;
    int miscompares = 0, num_checks = 0, nrep, ntare, np, n;
    initial forever #5 clk_i = ~clk_i;
    asgcp_parser #(.MS_CYCLES(10)) i_asgcp_parser (.clk_i(clk_i),
        .resetn_i(resetn_i), .rx_data_i(data), .rx_valid_i(valid),
        .rx_ready_o(ready), .sp_source_serial_i(src), .bidir_i(bidir),
        .autozero_en_i(az), .panel_btn_i(btn), .panel_btn_o(pbtn),
        .lockout_indicator_o(lock), .setpoint_o(sp), .setpoint_raw_o(raw),
        .gas_o(gas), .valve_mode_o(vm), .tare_flow_o(tare),
        .tare_abs_pressure_cmd_o(pabs), .unit_id_o(uid), .streaming_o(strm),
        .stream_interval_o(ivl), .stream_tick_o(tick), .reply_o(rep),
        .mix_o(mix), .mix_used_o(used));
    asgcp_host i_asgcp_host (.clk_i(clk_i), .ready_i(ready), .data_o(data),
        .valid_o(valid));
    // Pulses are counted mid-cycle, clear of the edge that makes them
    always @(negedge clk_i) begin
        if (rep.valid === 1'b1) begin
            nrep++;
            lastk = rep.kind;
        end
        if (tare === 1'b1) ntare++;
        if (pabs === 1'b1) np++;
    end
    task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd(string s);
        nrep = 0;
        i_asgcp_host.send({s, "\015"});
        repeat (3) @(posedge clk_i);
        #1;
    endtask : cmd
    task automatic rc(asgcp_rep_kind_t k);
        chk("reply count", nrep, 1);
        chk("reply kind", lastk, k);
    endtask : rc
    task automatic wt;
        n = 0;
        do @(posedge clk_i) #1 n++; while (tick !== 1'b1 && n < 100);
    endtask : wt
    task automatic t_setpoint;
        cmd("As-1.5");
        chk("setpoint", sp, -150);
        rc(REP_FRAME);
        bidir = 0;
        cmd("as-2");
        chk("setpoint", sp, -150);
        src = 0;
        cmd("aS7");
        chk("setpoint", sp, -150);
        src = 1;
        cmd("a25");
        chk("setpoint", {sp, raw}, {25'd25, 1'b1});
        $display("setpoint test done");
    endtask : t_setpoint
    task automatic t_gas;
        cmd("ag8");
        chk("gas", gas, 8);
        cmd("ag255");
        chk("gas", gas, 8);
        cmd("agm MyGas-7 0 50 8 50 7");
        chk("mixes", used, 0);
        i_asgcp_host.gap = 2;
        cmd("agm Mix.1 0 50 8 50.00 7");
        chk("mixes", used, 20'h80000);
        i_asgcp_host.gap = 0;
        cmd("AGM m-2 0 25.5 8 74.5 7");
        chk("mixes", used, 20'hc0000);
        rc(REP_MIX);
        chk("mix", {mix.num, mix.count}, {8'hfe, 3'h2});
        cmd("agm x 254 60 8 30 7");
        chk("mixes", used, 20'hc0000);
        cmd("agm x 254 60 8 40 7");
        chk("pct", mix.pct[0], 6000);
        cmd("ag255");
        chk("gas", gas, 255);
        cmd("agd 255");
        chk("mixes", used, 20'h40000);
        rc(REP_ACK);
        $display("gas test done");
    endtask : t_gas
    task automatic t_modes;
        cmd("aHP");
        chk("valve", vm, VALVE_HOLD_POS);
        cmd("ahc");
        chk("valve", vm, VALVE_HOLD_CLOSED);
        cmd("ac");
        chk("valve", vm, VALVE_RUN);
        cmd("al");
        chk("panel", {lock, pbtn}, 5'h10);
        cmd("aU");
        chk("panel", {lock, pbtn}, 5'h0f);
        cmd("apc");
        chk("pressure tare", np, 1);
        cmd("av");
        chk("flow tare", ntare, 1);
        $display("mode test done");
    endtask : t_modes
    task automatic t_stream;
        chk("interval", ivl, 50);
        cmd("aw91=3");
        chk("interval", ivl, 3);
        rc(REP_ACK);
        cmd("a@=@");
        chk("stream", {strm, uid}, 9'h140);
        repeat (2) wt();
        chk("tick gap", n, 30);
        cmd("@@=b");
        chk("stream", {strm, uid}, 9'h042);
        cmd("ag9");
        chk("gas", gas, 8'hff);
        cmd("bzz");
        chk("replies", nrep, 0);
        cmd("b");
        rc(REP_FRAME);
        cmd("b??M9");
        rc(REP_FW);
        cmd("ave");
        rc(REP_FW);
        $display("stream test done");
    endtask : t_stream
    task automatic t_zero;
        az = 1;
        cmd("bs0");
        ntare = 0;
        repeat (19900) @(posedge clk_i);
        chk("early tare", ntare, 0);
        repeat (200) @(posedge clk_i);
        chk("tare", ntare, 1);
        $display("zero test done");
    endtask : t_zero
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge clk_i);
        #1 resetn_i = 1;
        repeat (3) @(posedge clk_i);
        #1;
        t_setpoint();
        t_gas();
        t_modes();
        t_stream();
        t_zero();
        wrap_up();
    end
    // About two and a half times the expected run, so only a hang trips it
    initial begin
        #500000;
        miscompares++;
        wrap_up();
    end
endmodule : tb_ascii_setpoint_gas_cmd_parser
`default_nettype wire
